// File: rtl/p5g_map.svh
// How it works
// - each pin has two config bits: 00 input, 01 output, 10 open-drain, 11 alternative
// - upper config bits [7:6] set pin 7; alternative is channel 1 serial clock
// - upper config bits [5:4] set pin 6; alternative is channel 1 master-in line
// - upper config bits [3:2] set pin 5; alternative channel 1 master-out or two-wire data 0
// - upper config bits [1:0] set pin 4; alternative channel 1 select or two-wire clock 0
// - lower config bits [7:6] set pin 3; alternative is channel 0 serial clock
// - lower config bits [5:4] set pin 2; alternative is channel 0 master-in line
// - lower config bits [3:2] set pin 1; alternative channel 0 master-out or two-wire data 1
// - lower config bits [1:0] set pin 0; alternative channel 0 select or two-wire clock 1
// - pull-up register bit n enables the pull-up on pin n
// - bits 31 to 8 of the six port registers read zero, writes ignored
// - registers sit at 0x0500, 0x0504, 0x0514, 0x0518, 0x051c and 0x0520 from the port base
// - reset clears every config field to input and every pull-up enable
// - function select bits 5,4,1,0 pick serial (0) or two-wire (1); bits 3:2 reserved
`ifndef P5G_MAP_SVH
`define P5G_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define P5G_OFF_CFG_HIGH 12'h500
`define P5G_OFF_CFG_LOW 12'h504
`define P5G_OFF_PULLUP 12'h514
`define P5G_OFF_FSEL 12'h518
`define P5G_OFF_DATA 12'h51c
`define P5G_OFF_PIN_LEVEL 12'h520

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define P5G_FIELD_W 2
`define P5G_REG_W 8
`define P5G_FSEL_W 6
`define P5G_FSEL_WMASK 6'h33
`define P5G_FSEL_PIN5 5
`define P5G_FSEL_PIN4 4
`define P5G_FSEL_PIN1 1
`define P5G_FSEL_PIN0 0
`define P5G_RST_CFG 8'h00
`define P5G_RST_PULLUP 8'h00
`define P5G_RST_FSEL 6'h00
`define P5G_RST_DATA 8'h00

// ----------------------------------------------------------------
// pin mode codes and bus responses
// ----------------------------------------------------------------
`define P5G_MODE_IN 2'h0
`define P5G_MODE_OUT 2'h1
`define P5G_MODE_OD 2'h2
`define P5G_MODE_ALT 2'h3
`define P5G_RESP_OKAY 2'h0
`define P5G_RESP_SLVERR 2'h2

`endif

// File: rtl/p5g_pkg.sv
`include "p5g_map.svh"

package p5g_pkg;

	typedef enum logic [1:0] {
		P5G_MODE_INPUT = `P5G_MODE_IN,
		P5G_MODE_OUTPUT = `P5G_MODE_OUT,
		P5G_MODE_OPEN_DRAIN = `P5G_MODE_OD,
		P5G_MODE_ALTERNATE = `P5G_MODE_ALT
	} p5g_mode_t;

	typedef enum logic [1:0] {
		P5G_WS_IDLE = 2'b01,
		P5G_WS_RESP = 2'b10
	} p5g_wstate_t;

	typedef enum logic [1:0] {
		P5G_RS_IDLE = 2'b01,
		P5G_RS_DATA = 2'b10
	} p5g_rstate_t;

	typedef enum logic [2:0] {
		P5G_SEL_NONE,
		P5G_SEL_CFG_HIGH,
		P5G_SEL_CFG_LOW,
		P5G_SEL_PULLUP,
		P5G_SEL_FSEL,
		P5G_SEL_DATA,
		P5G_SEL_PIN_LEVEL
	} p5g_sel_t;

endpackage : p5g_pkg

// File: rtl/p5g_pin_cell.sv
`timescale 1ns/1ps
`include "p5g_map.svh"

module p5g_pin_cell
	import p5g_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire p5g_mode_t mode,
	input wire logic data_bit,
	input wire logic alt_o,
	input wire logic alt_oe,
	output logic pad_o,
	output logic pad_oe
);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pad_o <= 1'b0;
			pad_oe <= 1'b0;
		end
		else if (ce)
		begin
			case (mode)
				P5G_MODE_INPUT:
				begin
					pad_o <= 1'b0;
					pad_oe <= 1'b0;
				end
				P5G_MODE_OUTPUT:
				begin
					pad_o <= data_bit;
					pad_oe <= 1'b1;
				end
				P5G_MODE_OPEN_DRAIN:
				begin
					// only ever drives low, a one releases the pad
					pad_o <= 1'b0;
					pad_oe <= ~data_bit;
				end
				P5G_MODE_ALTERNATE:
				begin
					pad_o <= alt_o;
					pad_oe <= alt_oe;
				end
				default:
				begin
					pad_o <= 1'b0;
					pad_oe <= 1'b0;
				end
			endcase
		end
	end

endmodule : p5g_pin_cell

// File: rtl/p5g_top.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "p5g_map.svh"

module p5g_top
	import p5g_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int PIN_COUNT = 8
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [PIN_COUNT-1:0] pin_in,
	output logic [PIN_COUNT-1:0] pin_out,
	output logic [PIN_COUNT-1:0] pin_oe,
	output logic [PIN_COUNT-1:0] pin_pullup_en,
	input wire logic serial_clock_chan0_o,
	input wire logic serial_clock_chan0_oe,
	output logic serial_clock_chan0_i,
	input wire logic master_in_chan0_o,
	input wire logic master_in_chan0_oe,
	output logic master_in_chan0_i,
	input wire logic master_out_chan0_o,
	input wire logic master_out_chan0_oe,
	output logic master_out_chan0_i,
	input wire logic slave_select_chan0_o,
	input wire logic slave_select_chan0_oe,
	output logic slave_select_chan0_i,
	input wire logic serial_clock_chan1_o,
	input wire logic serial_clock_chan1_oe,
	output logic serial_clock_chan1_i,
	input wire logic master_in_chan1_o,
	input wire logic master_in_chan1_oe,
	output logic master_in_chan1_i,
	input wire logic master_out_chan1_o,
	input wire logic master_out_chan1_oe,
	output logic master_out_chan1_i,
	input wire logic slave_select_chan1_o,
	input wire logic slave_select_chan1_oe,
	output logic slave_select_chan1_i,
	input wire logic twowire_data_chan0_low,
	output logic twowire_data_chan0_i,
	input wire logic twowire_clock_chan0_low,
	output logic twowire_clock_chan0_i,
	input wire logic twowire_data_chan1_low,
	output logic twowire_data_chan1_i,
	input wire logic twowire_clock_chan1_low,
	output logic twowire_clock_chan1_i
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (PIN_COUNT != 8)
	begin : g_bad_pins
		$error("p5g_top: pin routing is fixed to eight pins");
	end
	if (ADDR_W < 12 || ADDR_W > 32)
	begin : g_bad_addr
		$error("p5g_top: address width must be 12 to 32");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	p5g_wstate_t ws_r;
	p5g_rstate_t rs_r;
	logic aw_have_r;
	logic w_have_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [`P5G_REG_W-1:0] cfg_high_r;
	logic [`P5G_REG_W-1:0] cfg_low_r;
	logic [`P5G_REG_W-1:0] pullup_r;
	logic [`P5G_FSEL_W-1:0] fsel_r;
	logic [`P5G_REG_W-1:0] data_r;
	logic [`P5G_REG_W-1:0] pin_level_r;
	logic wr_fire;
	logic wr_en;
	p5g_sel_t wr_sel;
	p5g_sel_t rd_sel;
	logic [`P5G_REG_W-1:0] rd_val;
	logic [2*PIN_COUNT-1:0] cfg_all;
	logic [PIN_COUNT-1:0] alt_on;
	logic [PIN_COUNT-1:0] alt_o;
	logic [PIN_COUNT-1:0] alt_oe;

	// ----------------------------------------------------------------
	// address decode, shared by read and write paths
	// ----------------------------------------------------------------
	function automatic p5g_sel_t p5g_decode(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] w;
		w = {a[ADDR_W-1:2], 2'b00};
		if (w == ADDR_W'(`P5G_OFF_CFG_HIGH))
			return P5G_SEL_CFG_HIGH;
		else if (w == ADDR_W'(`P5G_OFF_CFG_LOW))
			return P5G_SEL_CFG_LOW;
		else if (w == ADDR_W'(`P5G_OFF_PULLUP))
			return P5G_SEL_PULLUP;
		else if (w == ADDR_W'(`P5G_OFF_FSEL))
			return P5G_SEL_FSEL;
		else if (w == ADDR_W'(`P5G_OFF_DATA))
			return P5G_SEL_DATA;
		else if (w == ADDR_W'(`P5G_OFF_PIN_LEVEL))
			return P5G_SEL_PIN_LEVEL;
		else
			return P5G_SEL_NONE;
	endfunction : p5g_decode

	assign wr_sel = p5g_decode(awaddr_r);
	assign rd_sel = p5g_decode(s_axi_araddr);
	assign wr_fire = (ws_r == P5G_WS_IDLE) && aw_have_r && w_have_r;
	// data lives in lane 0 only; other lanes are dropped
	assign wr_en = wr_fire && wstrb_r[0];

	// ----------------------------------------------------------------
	// write channel: address and data taken in either order
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ws_r <= P5G_WS_IDLE;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `P5G_RESP_OKAY;
		end
		else if (ce)
		begin
			case (ws_r)
				P5G_WS_IDLE:
				begin
					if (s_axi_awvalid && s_axi_awready)
					begin
						aw_have_r <= 1'b1;
						awaddr_r <= s_axi_awaddr;
						s_axi_awready <= 1'b0;
					end
					else if (!aw_have_r)
						s_axi_awready <= 1'b1;
					if (s_axi_wvalid && s_axi_wready)
					begin
						w_have_r <= 1'b1;
						wdata_r <= s_axi_wdata;
						wstrb_r <= s_axi_wstrb;
						s_axi_wready <= 1'b0;
					end
					else if (!w_have_r)
						s_axi_wready <= 1'b1;
					if (wr_fire)
					begin
						ws_r <= P5G_WS_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= (wr_sel == P5G_SEL_NONE) ? `P5G_RESP_SLVERR : `P5G_RESP_OKAY;
					end
				end
				P5G_WS_RESP:
				begin
					if (s_axi_bready)
					begin
						s_axi_bvalid <= 1'b0;
						aw_have_r <= 1'b0;
						w_have_r <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready <= 1'b1;
						ws_r <= P5G_WS_IDLE;
					end
				end
				default:
				begin
					ws_r <= P5G_WS_IDLE;
					aw_have_r <= 1'b0;
					w_have_r <= 1'b0;
					s_axi_bvalid <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	always_comb
	begin
		case (rd_sel)
			P5G_SEL_CFG_HIGH: rd_val = cfg_high_r;
			P5G_SEL_CFG_LOW: rd_val = cfg_low_r;
			P5G_SEL_PULLUP: rd_val = pullup_r;
			P5G_SEL_FSEL: rd_val = {2'h0, fsel_r};
			P5G_SEL_DATA: rd_val = data_r;
			P5G_SEL_PIN_LEVEL: rd_val = pin_level_r;
			default: rd_val = '0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rs_r <= P5G_RS_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `P5G_RESP_OKAY;
		end
		else if (ce)
		begin
			case (rs_r)
				P5G_RS_IDLE:
				begin
					if (s_axi_arvalid && s_axi_arready)
					begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid <= 1'b1;
						s_axi_rdata <= {24'h0, rd_val};
						s_axi_rresp <= (rd_sel == P5G_SEL_NONE) ? `P5G_RESP_SLVERR : `P5G_RESP_OKAY;
						rs_r <= P5G_RS_DATA;
					end
					else
						s_axi_arready <= 1'b1;
				end
				P5G_RS_DATA:
				begin
					if (s_axi_rready)
					begin
						s_axi_rvalid <= 1'b0;
						s_axi_arready <= 1'b1;
						rs_r <= P5G_RS_IDLE;
					end
				end
				default:
				begin
					rs_r <= P5G_RS_IDLE;
					s_axi_rvalid <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// port registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_high_r <= `P5G_RST_CFG;
			cfg_low_r <= `P5G_RST_CFG;
		end
		else if (ce && wr_en)
		begin
			if (wr_sel == P5G_SEL_CFG_HIGH)
				cfg_high_r <= wdata_r[`P5G_REG_W-1:0];
			if (wr_sel == P5G_SEL_CFG_LOW)
				cfg_low_r <= wdata_r[`P5G_REG_W-1:0];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pullup_r <= `P5G_RST_PULLUP;
		else if (ce && wr_en && wr_sel == P5G_SEL_PULLUP)
			pullup_r <= wdata_r[`P5G_REG_W-1:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fsel_r <= `P5G_RST_FSEL;
		else if (ce && wr_en && wr_sel == P5G_SEL_FSEL)
			fsel_r <= wdata_r[`P5G_FSEL_W-1:0] & `P5G_FSEL_WMASK;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			data_r <= `P5G_RST_DATA;
		else if (ce && wr_en && wr_sel == P5G_SEL_DATA)
			data_r <= wdata_r[`P5G_REG_W-1:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_level_r <= '0;
			pin_pullup_en <= '0;
		end
		else if (ce)
		begin
			pin_level_r <= pin_in;
			pin_pullup_en <= pullup_r;
		end
	end

	// ----------------------------------------------------------------
	// alternative function routing
	// ----------------------------------------------------------------
	// pin n field sits at bits 2n+1:2n of the joined pair
	assign cfg_all = {cfg_high_r, cfg_low_r};

	always_comb
	begin
		alt_o[7] = serial_clock_chan1_o;
		alt_oe[7] = serial_clock_chan1_oe;
		alt_o[6] = master_in_chan1_o;
		alt_oe[6] = master_in_chan1_oe;
		// two-wire lines only pull low, matching their open-drain bus
		alt_o[5] = fsel_r[`P5G_FSEL_PIN5] ? 1'b0 : master_out_chan1_o;
		alt_oe[5] = fsel_r[`P5G_FSEL_PIN5] ? twowire_data_chan0_low : master_out_chan1_oe;
		alt_o[4] = fsel_r[`P5G_FSEL_PIN4] ? 1'b0 : slave_select_chan1_o;
		alt_oe[4] = fsel_r[`P5G_FSEL_PIN4] ? twowire_clock_chan0_low : slave_select_chan1_oe;
		alt_o[3] = serial_clock_chan0_o;
		alt_oe[3] = serial_clock_chan0_oe;
		alt_o[2] = master_in_chan0_o;
		alt_oe[2] = master_in_chan0_oe;
		alt_o[1] = fsel_r[`P5G_FSEL_PIN1] ? 1'b0 : master_out_chan0_o;
		alt_oe[1] = fsel_r[`P5G_FSEL_PIN1] ? twowire_data_chan1_low : master_out_chan0_oe;
		alt_o[0] = fsel_r[`P5G_FSEL_PIN0] ? 1'b0 : slave_select_chan0_o;
		alt_oe[0] = fsel_r[`P5G_FSEL_PIN0] ? twowire_clock_chan1_low : slave_select_chan0_oe;
	end

	// unrouted controller inputs rest at the line's idle level
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			serial_clock_chan1_i <= 1'b0;
			master_in_chan1_i <= 1'b0;
			master_out_chan1_i <= 1'b0;
			slave_select_chan1_i <= 1'b1;
			twowire_data_chan0_i <= 1'b1;
			twowire_clock_chan0_i <= 1'b1;
			serial_clock_chan0_i <= 1'b0;
			master_in_chan0_i <= 1'b0;
			master_out_chan0_i <= 1'b0;
			slave_select_chan0_i <= 1'b1;
			twowire_data_chan1_i <= 1'b1;
			twowire_clock_chan1_i <= 1'b1;
		end
		else if (ce)
		begin
			serial_clock_chan1_i <= alt_on[7] & pin_in[7];
			master_in_chan1_i <= alt_on[6] & pin_in[6];
			master_out_chan1_i <= alt_on[5] & ~fsel_r[`P5G_FSEL_PIN5] & pin_in[5];
			slave_select_chan1_i <= ~(alt_on[4] & ~fsel_r[`P5G_FSEL_PIN4]) | pin_in[4];
			twowire_data_chan0_i <= ~(alt_on[5] & fsel_r[`P5G_FSEL_PIN5]) | pin_in[5];
			twowire_clock_chan0_i <= ~(alt_on[4] & fsel_r[`P5G_FSEL_PIN4]) | pin_in[4];
			serial_clock_chan0_i <= alt_on[3] & pin_in[3];
			master_in_chan0_i <= alt_on[2] & pin_in[2];
			master_out_chan0_i <= alt_on[1] & ~fsel_r[`P5G_FSEL_PIN1] & pin_in[1];
			slave_select_chan0_i <= ~(alt_on[0] & ~fsel_r[`P5G_FSEL_PIN0]) | pin_in[0];
			twowire_data_chan1_i <= ~(alt_on[1] & fsel_r[`P5G_FSEL_PIN1]) | pin_in[1];
			twowire_clock_chan1_i <= ~(alt_on[0] & fsel_r[`P5G_FSEL_PIN0]) | pin_in[0];
		end
	end

	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	for (genvar n = 0; n < PIN_COUNT; n++)
	begin : g_pin
		assign alt_on[n] = (cfg_all[2*n +: `P5G_FIELD_W] == `P5G_MODE_ALT);

		p5g_pin_cell u_cell (
			.aclk(aclk),
			.aresetn(aresetn),
			.ce(ce),
			.mode(p5g_mode_t'(cfg_all[2*n +: `P5G_FIELD_W])),
			.data_bit(data_r[n]),
			.alt_o(alt_o[n]),
			.alt_oe(alt_oe[n]),
			.pad_o(pin_out[n]),
			.pad_oe(pin_oe[n])
		);
	end

endmodule : p5g_top

// File: dv/p5g_props.sv
`timescale 1ns/1ps
module p5g_props
#(
	parameter int ADDR_W = 12,
	parameter int PIN_COUNT = 8
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [PIN_COUNT-1:0] pin_out,
	input wire logic [PIN_COUNT-1:0] pin_oe,
	input wire logic [PIN_COUNT-1:0] pin_pullup_en
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ----
	// handshake steps
	// ----
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_wr_answer;
		s_wr_take |=> (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
	property p_b_release;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
	endproperty
	a_b_release: assert property (p_b_release) else $error("write channel not reopened");
	property p_rd_answer;
		s_rd_take |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_r_release;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_r_release: assert property (p_r_release) else $error("read channel not reopened");
	property p_rdata_upper;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
	property p_reset_state;
		$rose(aresetn) |-> pin_oe == '0 && pin_pullup_en == '0 && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("state not cleared by reset");
	// pull-up copy may lag the register write by one edge
	property p_pullup_cause;
		$changed(pin_pullup_en) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_pullup_cause: assert property (p_pullup_cause) else $error("pull-up moved without a write");
	property p_ce_freeze;
		!ce |=> $stable(pin_oe) && $stable(pin_out) && $stable(pin_pullup_en);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("pins moved while disabled");
endmodule : p5g_props

bind p5g_top p5g_props #(.ADDR_W(ADDR_W), .PIN_COUNT(PIN_COUNT)) p5g_props_inst (.aclk(aclk), .aresetn(aresetn),
	.ce(ce), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .pin_out(pin_out), .pin_oe(pin_oe),
	.pin_pullup_en(pin_pullup_en));

// File: dv/p5g_pad_model.sv
`timescale 1ns/1ps
module p5g_pad_model
(
	input wire logic aclk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup_en,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	output logic [7:0] pin_in
);
	// undriven, unpulled pads wander so a stale level never looks valid
	logic [7:0] float_r = 8'h00;
	always_ff @(posedge aclk)
	begin
		float_r <= ~float_r;
	end
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pin_pullup_en | float_r));
endmodule : p5g_pad_model

// File: dv/p5g_top_tb.sv
`timescale 1ns/1ps
module p5g_top_tb;
	localparam logic [7:0] DAT = 8'ha5;
	localparam logic [7:0] TW_PIN = 8'h33;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [7:0] so = 8'h00, soe = 8'h00, ext_val = 8'h00, ext_en = 8'h00;
	logic [7:0] pin_in, pin_out, pin_oe, pin_pu, si, hi, lo, eo, eoe;
	logic [3:0] tw_low = 4'h0, twi;
	logic [3:0] strb = 4'hf;
	logic [11:0] regs [4] = '{12'h500, 12'h504, 12'h514, 12'h518};
	int num_errors = 0, samples_checked = 0, i, r, p, f, m;
	always #4 aclk = ~aclk;
	p5g_top p5g_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pu),
		.serial_clock_chan0_o(so[3]), .serial_clock_chan0_oe(soe[3]), .serial_clock_chan0_i(si[3]),
		.master_in_chan0_o(so[2]), .master_in_chan0_oe(soe[2]), .master_in_chan0_i(si[2]),
		.master_out_chan0_o(so[1]), .master_out_chan0_oe(soe[1]), .master_out_chan0_i(si[1]),
		.slave_select_chan0_o(so[0]), .slave_select_chan0_oe(soe[0]), .slave_select_chan0_i(si[0]),
		.serial_clock_chan1_o(so[7]), .serial_clock_chan1_oe(soe[7]), .serial_clock_chan1_i(si[7]),
		.master_in_chan1_o(so[6]), .master_in_chan1_oe(soe[6]), .master_in_chan1_i(si[6]),
		.master_out_chan1_o(so[5]), .master_out_chan1_oe(soe[5]), .master_out_chan1_i(si[5]),
		.slave_select_chan1_o(so[4]), .slave_select_chan1_oe(soe[4]), .slave_select_chan1_i(si[4]),
		.twowire_data_chan0_low(tw_low[3]), .twowire_data_chan0_i(twi[3]),
		.twowire_clock_chan0_low(tw_low[2]), .twowire_clock_chan0_i(twi[2]),
		.twowire_data_chan1_low(tw_low[1]), .twowire_data_chan1_i(twi[1]),
		.twowire_clock_chan1_low(tw_low[0]), .twowire_clock_chan1_i(twi[0]));
	p5g_pad_model p5g_pad_model_inst (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup_en(pin_pu), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
	// ----
	// checks and bus tasks
	// ----
	task automatic complete_run;
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t bus value %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_pins(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t pins %h expected %h", $time, got, exp);
		end
	endtask : chk_pins
	task automatic bus_timeout;
		num_errors++;
		$display("[ERR] %0t bus timeout", $time);
		complete_run();
	endtask : bus_timeout
	// bready held from the start, so the answer is taken where it is seen
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		if (n == 50)
			bus_timeout();
		bready <= 1'b0;
		chk_word({30'h0, bresp}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		if (n == 50)
			bus_timeout();
		rready <= 1'b0;
		chk_word(rdata, exp);
		chk_word({30'h0, rresp}, {30'h0, er});
	endtask : rd
	// ----
	// main sequence
	// ----
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		so <= 8'h96;
		soe <= 8'hc3;
		tw_low <= 4'h9;
		chk_pins(pin_oe, 8'h00);
		for (i = 0; i < 4; i++)
			rd(regs[i], 32'h0, 2'h0);
		for (i = 0; i < 4; i++)
		begin
			wr(regs[i], 32'hffffffff, 2'h0);
			rd(regs[i], (i == 3) ? 32'h33 : 32'hff, 2'h0);
		end
		wr(12'h508, 32'hff, 2'h2);
		rd(12'h50c, 32'h0, 2'h2);
		wr(12'h514, 32'h81, 2'h0);
		repeat (3) @(posedge aclk);
		chk_pins(pin_pu, 8'h81);
		// lane 0 strobe off: answered but nothing stored
		strb <= 4'he;
		wr(12'h514, 32'h0, 2'h0);
		strb <= 4'hf;
		rd(12'h514, 32'h81, 2'h0);
		wr(12'h51c, {24'h0, DAT}, 2'h0);
		// every pin sees every mode, with and without the two-wire choice
		for (f = 0; f < 2; f++)
		begin
			wr(12'h518, f ? 32'h33 : 32'h0, 2'h0);
			for (r = 0; r < 4; r++)
			begin
				for (p = 0; p < 8; p++)
				begin
					m = (p + r) % 4;
					if (p > 3)
						hi[2*(p-4)+:2] = m[1:0];
					else
						lo[2*p+:2] = m[1:0];
					eo[p] = (m == 1) ? DAT[p] : (m == 3 && !(f && TW_PIN[p])) ? so[p] : 1'b0;
					eoe[p] = (m == 1) ? 1'b1 : (m == 2) ? ~DAT[p] : (m != 3) ? 1'b0
						: (f && TW_PIN[p]) ? tw_low[p > 3 ? p - 2 : p] : soe[p];
				end
				wr(12'h500, {24'h0, hi}, 2'h0);
				wr(12'h504, {24'h0, lo}, 2'h0);
				repeat (3) @(posedge aclk);
				chk_pins(pin_out, eo);
				chk_pins(pin_oe, eoe);
			end
		end
		soe <= 8'h00;
		tw_low <= 4'h0;
		ext_en <= 8'hff;
		ext_val <= 8'h5a;
		wr(12'h500, 32'hff, 2'h0);
		wr(12'h504, 32'hff, 2'h0);
		wr(12'h518, 32'h0, 2'h0);
		repeat (3) @(posedge aclk);
		chk_pins(si, 8'h5a);
		chk_pins({4'h0, twi}, 8'h0f);
		rd(12'h520, 32'h5a, 2'h0);
		wr(12'h518, 32'h33, 2'h0);
		repeat (3) @(posedge aclk);
		chk_pins(si, 8'h59);
		chk_pins({4'h0, twi}, 8'h06);
		ce <= 1'b0;
		@(posedge aclk);
		so <= 8'h69;
		repeat (3) @(posedge aclk);
		chk_pins(pin_out, 8'h84);
		ce <= 1'b1;
		repeat (3) @(posedge aclk);
		chk_pins(pin_out, 8'h48);
		// mid-run reset must clear the four registers in regs, the pin outputs and the pull-up enables
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		chk_pins(pin_out, 8'h00);
		chk_pins(pin_pu, 8'h00);
		for (i = 0; i < 4; i++)
			rd(regs[i], 32'h0, 2'h0);
		repeat (3) @(posedge aclk);
		complete_run();
	end
endmodule : p5g_top_tb
